// *** src/dapm_core.sv ***
// command front end: taskfile registers, addressing, power modes
// assumes taskfile strobes synchronous to clk; soft_rst is a one-cycle pulse
`include "dapm_cfg.svh"
module dapm_core #(
	parameter int unsigned SPINUP_CYCLES = `DAPM_SPINUP_MS * 1000 * `DAPM_CLK_MHZ,
	parameter int unsigned TMR_UNIT_CYCLES = `DAPM_TMR_UNIT_MS * 1000 * `DAPM_CLK_MHZ,
	parameter int unsigned MEDIA_CYCLES = `DAPM_MEDIA_CYCLES,
	parameter int unsigned TOTAL_SECTORS = `DAPM_TOTAL_SECTORS,
	parameter int unsigned DEF_SPT = `DAPM_DEF_SPT,
	parameter int unsigned DEF_HPC = `DAPM_DEF_HPC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic soft_rst,
	input wire logic cache_busy,
	input wire logic tf_wr,
	input wire logic tf_rd,
	input wire logic [3:0] tf_sel,
	input wire logic [7:0] tf_wdata,
	output logic [7:0] tf_rdata,
	output logic [7:0] status,
	output logic [4:0] power_mode,
	output logic iface_active,
	output logic media_spin,
	output logic media_req,
	output logic [27:0] media_lba
);
	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	if (SPINUP_CYCLES < 1 || TMR_UNIT_CYCLES < 1 || MEDIA_CYCLES < 1) begin : g_bad_time
		$error("timing counts must be at least one cycle");
	end
	if (DEF_SPT < 1 || DEF_SPT > 255 || DEF_HPC < 1 || DEF_HPC > 16) begin : g_bad_geom
		$error("default geometry out of range");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	dapm_pkg::dapm_pwr_t pwr_q, pwr_d;
	dapm_pkg::dapm_exec_t ex_q, ex_d;
	logic [7:0] scnt_q, snum_q, clo_q, chi_q, dh_q, err_q;
	logic [7:0] stat_q, rdata_q;
	logic bsy_q;
	logic tmr_en_q;
	logic [7:0] tmr_load_q, tmr_left_q;
	logic [31:0] tmr_pre_q, spin_cnt_q, media_cnt_q;
	logic iface_q, spin_q, mreq_q;
	logic [27:0] mlba_q;

	dapm_xlate_if xif();

	dapm_xlate #(
		.TOTAL_SECTORS(TOTAL_SECTORS),
		.DEF_SPT(DEF_SPT),
		.DEF_HPC(DEF_HPC)
	) u_xlate (
		.clk(clk),
		.nrst(nrst),
		.xif(xif)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// writes are dropped while busy or asleep; a dead interface hears nothing
	wire live = (pwr_q != dapm_pkg::pm_sleep);
	wire reg_wr = tf_wr && live && !bsy_q && !soft_rst;
	wire cmd_go = reg_wr && (tf_sel == `DAPM_TF_STAT);
	wire [7:0] cmd = tf_wdata;
	wire c_idle = (cmd == `DAPM_CMD_IDLE) || (cmd == `DAPM_CMD_IDLE_IMM);
	wire c_stby = (cmd == `DAPM_CMD_STBY) || (cmd == `DAPM_CMD_STBY_IMM);
	wire c_timed = (cmd == `DAPM_CMD_IDLE) || (cmd == `DAPM_CMD_STBY);
	wire c_media = (cmd == `DAPM_CMD_READ) || (cmd == `DAPM_CMD_WRITE);
	wire c_chk = (cmd == `DAPM_CMD_CHKPWR);
	wire c_sleep = (cmd == `DAPM_CMD_SLEEP);
	wire c_initp = (cmd == `DAPM_CMD_INITP);
	wire c_known = c_idle || c_stby || c_media || c_chk || c_sleep || c_initp;
	wire media_ok = cmd_go && c_media && xif.in_range;
	wire abort = cmd_go && (!c_known || (c_media && !xif.in_range));
	wire spun = (pwr_q == dapm_pkg::pm_active) || (pwr_q == dapm_pkg::pm_idle);
	wire spin_done = (ex_q == dapm_pkg::ex_spin) && (spin_cnt_q == 32'h0);
	wire media_done = (ex_q == dapm_pkg::ex_media) && (media_cnt_q == 32'h0);
	wire tmr_expire = tmr_en_q && spun && !bsy_q && (tmr_pre_q == 32'h0) && (tmr_left_q == 8'h1);
	wire [7:0] pwr_code = (pwr_q == dapm_pkg::pm_standby) ? `DAPM_PWR_STANDBY :
		(pwr_q == dapm_pkg::pm_spinup) ? `DAPM_PWR_LEAVING : `DAPM_PWR_SPUN;

	assign xif.lba_mode = dh_q[`DAPM_DH_LBA_BIT];
	assign xif.cyl = {chi_q, clo_q};
	assign xif.head = dh_q[3:0];
	assign xif.sect = snum_q;
	assign xif.geom_go = cmd_go && c_initp;
	assign xif.new_spt = scnt_q;
	assign xif.new_hpc = {1'b0, dh_q[3:0]} + 5'h1;

	// ----------------------------------------
	// command execution
	// ----------------------------------------
	always_comb begin
		ex_d = ex_q;
		case (ex_q)
			dapm_pkg::ex_ready: begin
				if (cmd_go && c_initp) begin
					ex_d = dapm_pkg::ex_geom;
				end else if (media_ok && pwr_q == dapm_pkg::pm_standby) begin
					ex_d = dapm_pkg::ex_spin;
				end else if (media_ok) begin
					ex_d = dapm_pkg::ex_media;
				end
			end
			dapm_pkg::ex_spin: if (spin_done) begin
				ex_d = dapm_pkg::ex_media;
			end
			dapm_pkg::ex_media: if (media_done) begin
				ex_d = dapm_pkg::ex_ready;
			end
			dapm_pkg::ex_geom: if (!xif.geom_busy) begin
				ex_d = dapm_pkg::ex_ready;
			end
			default: ex_d = dapm_pkg::ex_ready;
		endcase
		if (soft_rst) begin
			ex_d = dapm_pkg::ex_ready;
		end
	end

	// ----------------------------------------
	// power mode
	// ----------------------------------------
	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			dapm_pkg::pm_active: begin
				if (cmd_go && c_idle) pwr_d = dapm_pkg::pm_idle;
				else if (cmd_go && c_stby) pwr_d = dapm_pkg::pm_standby;
				else if (cmd_go && c_sleep) pwr_d = dapm_pkg::pm_sleep;
				else if (tmr_expire) pwr_d = dapm_pkg::pm_standby;
				else if (ex_q == dapm_pkg::ex_ready && !media_ok && !cache_busy) pwr_d = dapm_pkg::pm_idle;
			end
			dapm_pkg::pm_idle: begin
				if (cmd_go && c_stby) pwr_d = dapm_pkg::pm_standby;
				else if (cmd_go && c_sleep) pwr_d = dapm_pkg::pm_sleep;
				else if (media_ok || cache_busy) pwr_d = dapm_pkg::pm_active;
				else if (tmr_expire) pwr_d = dapm_pkg::pm_standby;
			end
			dapm_pkg::pm_standby: begin
				if (cmd_go && c_idle) pwr_d = dapm_pkg::pm_idle;
				else if (cmd_go && c_sleep) pwr_d = dapm_pkg::pm_sleep;
				else if (media_ok) pwr_d = dapm_pkg::pm_spinup;
			end
			dapm_pkg::pm_spinup: if (spin_done) begin
				pwr_d = dapm_pkg::pm_active;
			end
			dapm_pkg::pm_sleep: pwr_d = dapm_pkg::pm_sleep;
			default: pwr_d = dapm_pkg::pm_idle;
		endcase
		// a reset out of sleep or mid spin-up lands in standby, active drops to idle, else mode kept
		if (soft_rst && (pwr_q == dapm_pkg::pm_sleep || pwr_q == dapm_pkg::pm_spinup)) begin
			pwr_d = dapm_pkg::pm_standby;
		end else if (soft_rst) begin
			pwr_d = (pwr_q == dapm_pkg::pm_active) ? dapm_pkg::pm_idle : pwr_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pwr_q <= dapm_pkg::pm_idle;
			ex_q <= dapm_pkg::ex_ready;
		end else begin
			pwr_q <= pwr_d;
			ex_q <= ex_d;
		end
	end

	// ----------------------------------------
	// counters: spin-up, media, standby timer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			spin_cnt_q <= 32'h0;
			media_cnt_q <= 32'h0;
		end else begin
			spin_cnt_q <= (ex_d == dapm_pkg::ex_spin && ex_q != dapm_pkg::ex_spin) ? SPINUP_CYCLES - 1 :
				(spin_cnt_q != 32'h0) ? spin_cnt_q - 32'h1 : 32'h0;
			media_cnt_q <= (ex_d == dapm_pkg::ex_media && ex_q != dapm_pkg::ex_media) ? MEDIA_CYCLES - 1 :
				(media_cnt_q != 32'h0) ? media_cnt_q - 32'h1 : 32'h0;
		end
	end

	// timer is off after power-on; soft resets leave it alone
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tmr_en_q <= 1'b0;
			tmr_load_q <= 8'h0;
			tmr_left_q <= 8'h0;
			tmr_pre_q <= 32'h0;
		end else if (cmd_go && c_timed) begin
			tmr_en_q <= (scnt_q != 8'h0);
			tmr_load_q <= scnt_q;
			tmr_left_q <= scnt_q;
			tmr_pre_q <= TMR_UNIT_CYCLES - 1;
		end else if (cmd_go || bsy_q || tmr_expire) begin
			tmr_left_q <= tmr_load_q;
			tmr_pre_q <= TMR_UNIT_CYCLES - 1;
		end else if (tmr_en_q && spun) begin
			if (tmr_pre_q != 32'h0) begin
				tmr_pre_q <= tmr_pre_q - 32'h1;
			end else begin
				tmr_pre_q <= TMR_UNIT_CYCLES - 1;
				tmr_left_q <= tmr_left_q - 8'h1;
			end
		end
	end

	// ----------------------------------------
	// taskfile registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst || soft_rst) begin
			scnt_q <= `DAPM_SCNT_RST;
			snum_q <= `DAPM_SNUM_RST;
			clo_q <= `DAPM_ZERO8;
			chi_q <= `DAPM_ZERO8;
			dh_q <= `DAPM_ZERO8;
			err_q <= `DAPM_DIAG_OK;
		end else begin
			if (reg_wr && tf_sel == `DAPM_TF_SCNT) scnt_q <= tf_wdata;
			else if (cmd_go && c_chk) scnt_q <= pwr_code;
			if (reg_wr && tf_sel == `DAPM_TF_SNUM) snum_q <= tf_wdata;
			if (reg_wr && tf_sel == `DAPM_TF_CLO) clo_q <= tf_wdata;
			if (reg_wr && tf_sel == `DAPM_TF_CHI) chi_q <= tf_wdata;
			if (reg_wr && tf_sel == `DAPM_TF_DH) dh_q <= tf_wdata;
			if (abort) err_q <= `DAPM_ERR_ABRT;
			else if (cmd_go) err_q <= `DAPM_ZERO8;
		end
	end

	// ready stays up in every awake mode; it says nothing about the spindle
	wire bsy_d = (ex_d != dapm_pkg::ex_ready);
	wire err_d = abort || (!cmd_go && stat_q[`DAPM_ST_ERR] && !soft_rst);
	wire [7:0] stat_d = {bsy_d, 1'b1, 1'b0, 1'b1, 3'h0, err_d};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stat_q <= `DAPM_STAT_RST;
			bsy_q <= 1'b0;
			rdata_q <= `DAPM_ZERO8;
			iface_q <= 1'b1;
			spin_q <= 1'b1;
			mreq_q <= 1'b0;
			mlba_q <= 28'h0;
		end else begin
			stat_q <= stat_d;
			bsy_q <= bsy_d;
			iface_q <= (pwr_d != dapm_pkg::pm_sleep);
			spin_q <= (pwr_d == dapm_pkg::pm_active) || (pwr_d == dapm_pkg::pm_idle);
			mreq_q <= (ex_d == dapm_pkg::ex_media);
			if (media_ok) mlba_q <= xif.lba;
			if (tf_rd && live) begin
				case (tf_sel)
					`DAPM_TF_ERR: rdata_q <= err_q;
					`DAPM_TF_SCNT: rdata_q <= scnt_q;
					`DAPM_TF_SNUM: rdata_q <= snum_q;
					`DAPM_TF_CLO: rdata_q <= clo_q;
					`DAPM_TF_CHI: rdata_q <= chi_q;
					`DAPM_TF_DH: rdata_q <= dh_q;
					`DAPM_TF_STAT: rdata_q <= stat_q;
					`DAPM_TF_ALT: rdata_q <= stat_q;
					default: rdata_q <= `DAPM_ZERO8;
				endcase
			end
		end
	end

	assign tf_rdata = rdata_q;
	assign status = stat_q;
	assign power_mode = pwr_q;
	assign iface_active = iface_q;
	assign media_spin = spin_q;
	assign media_req = mreq_q;
	assign media_lba = mlba_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_sleep_holds: assert property (@(posedge clk) disable iff (!nrst)
		(pwr_q == dapm_pkg::pm_sleep && !soft_rst) |=> pwr_q == dapm_pkg::pm_sleep)
		else $error("left sleep without reset");
	a_wake_standby: assert property (@(posedge clk) disable iff (!nrst)
		(pwr_q == dapm_pkg::pm_sleep && soft_rst) |=> (pwr_q == dapm_pkg::pm_standby && iface_q))
		else $error("reset from sleep not standby");
	a_idle_cmd: assert property (@(posedge clk) disable iff (!nrst)
		(cmd_go && c_idle && pwr_q != dapm_pkg::pm_spinup) |=> pwr_q == dapm_pkg::pm_idle)
		else $error("idle command missed idle");
	a_stby_cmd: assert property (@(posedge clk) disable iff (!nrst)
		(cmd_go && c_stby && spun) |=> (pwr_q == dapm_pkg::pm_standby && !spin_q))
		else $error("standby command missed standby");
	a_tmr_off: assert property (@(posedge clk) disable iff (!nrst)
		(cmd_go && c_timed && scnt_q == 8'h0) |=> !tmr_en_q ##1 !tmr_expire)
		else $error("zero count left timer on");
	a_tmr_drop: assert property (@(posedge clk) disable iff (!nrst)
		(tmr_expire && !cmd_go && !soft_rst) |=> pwr_q == dapm_pkg::pm_standby ##1 !spin_q)
		else $error("timer expiry missed standby");
	a_spin_wait: assert property (@(posedge clk) disable iff (!nrst)
		(media_ok && pwr_q == dapm_pkg::pm_standby && !soft_rst) |=> !mreq_q [*2])
		else $error("media access before spin-up");
	a_idle_fast: assert property (@(posedge clk) disable iff (!nrst)
		(media_ok && pwr_q == dapm_pkg::pm_idle && !soft_rst) |=> mreq_q)
		else $error("idle media access delayed");
	a_media_active: assert property (@(posedge clk) disable iff (!nrst)
		(ex_q == dapm_pkg::ex_media && !soft_rst) |=> pwr_q inside {dapm_pkg::pm_active, dapm_pkg::pm_idle})
		else $error("media access outside active");
	a_ready_awake: assert property (@(posedge clk) disable iff (!nrst)
		(pwr_q inside {dapm_pkg::pm_idle, dapm_pkg::pm_standby} && $past(pwr_q) == pwr_q && !$past(bsy_q))
		|-> (stat_q[`DAPM_ST_RDY] && (!stat_q[`DAPM_ST_BSY] || $past(cmd_go))))
		else $error("idle or standby status wrong");
endmodule // dapm_core

// *** src/dapm_cfg.svh ***
// constants for the disk addressing and power mode block
// assumes a 25 MHz clock and an 8-bit taskfile port
`ifndef DAPM_CFG_SVH
`define DAPM_CFG_SVH
// ----------------------------------------
// taskfile register selects
// ----------------------------------------
`define DAPM_TF_ERR 4'h1
`define DAPM_TF_SCNT 4'h2
`define DAPM_TF_SNUM 4'h3
`define DAPM_TF_CLO 4'h4
`define DAPM_TF_CHI 4'h5
`define DAPM_TF_DH 4'h6
`define DAPM_TF_STAT 4'h7
`define DAPM_TF_ALT 4'he
// ----------------------------------------
// command codes
// ----------------------------------------
`define DAPM_CMD_STBY_IMM 8'he0
`define DAPM_CMD_IDLE_IMM 8'he1
`define DAPM_CMD_STBY 8'he2
`define DAPM_CMD_IDLE 8'he3
`define DAPM_CMD_CHKPWR 8'he5
`define DAPM_CMD_SLEEP 8'he6
`define DAPM_CMD_INITP 8'h91
`define DAPM_CMD_READ 8'h20
`define DAPM_CMD_WRITE 8'h30
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define DAPM_STAT_RST 8'h50
`define DAPM_SCNT_RST 8'h01
`define DAPM_SNUM_RST 8'h01
`define DAPM_ZERO8 8'h00
`define DAPM_DIAG_OK 8'h01
`define DAPM_ERR_ABRT 8'h04
`define DAPM_DH_LBA_BIT 6
`define DAPM_ST_BSY 7
`define DAPM_ST_RDY 6
`define DAPM_ST_DSC 4
`define DAPM_ST_ERR 0
`define DAPM_PWR_STANDBY 8'h00
`define DAPM_PWR_LEAVING 8'h80
`define DAPM_PWR_SPUN 8'hff
// ----------------------------------------
// timing and geometry
// ----------------------------------------
`define DAPM_CLK_MHZ 25
`define DAPM_SPINUP_MS 100
`define DAPM_TMR_UNIT_MS 5000
`define DAPM_MEDIA_CYCLES 8
`define DAPM_TOTAL_SECTORS 268435455
`define DAPM_DEF_SPT 63
`define DAPM_DEF_HPC 16
`define DAPM_MAX_CYLS 65535
`endif

// *** src/dapm_pkg.sv ***
// types shared by the disk addressing and power mode block
// assumes nothing beyond the compiler
package dapm_pkg;
	typedef enum logic [4:0] {
		pm_active = 5'b00001,
		pm_idle = 5'b00010,
		pm_standby = 5'b00100,
		pm_spinup = 5'b01000,
		pm_sleep = 5'b10000
	} dapm_pwr_t;
	typedef enum logic [3:0] {
		ex_ready = 4'b0001,
		ex_spin = 4'b0010,
		ex_media = 4'b0100,
		ex_geom = 4'b1000
	} dapm_exec_t;
endpackage

// *** src/dapm_xlate_if.sv ***
// address fields and geometry between command core and translator
// assumes both ends share one clock
interface dapm_xlate_if;
	logic lba_mode;
	logic [15:0] cyl;
	logic [3:0] head;
	logic [7:0] sect;
	logic geom_go;
	logic [7:0] new_spt;
	logic [4:0] new_hpc;
	logic geom_busy;
	logic [15:0] cyls;
	logic [27:0] lba;
	logic in_range;
	modport core(output lba_mode, output cyl, output head, output sect, output geom_go, output new_spt,
		output new_hpc, input geom_busy, input cyls, input lba, input in_range);
	modport xlate(input lba_mode, input cyl, input head, input sect, input geom_go, input new_spt,
		input new_hpc, output geom_busy, output cyls, output lba, output in_range);
endinterface

// *** src/dapm_xlate.sv ***
// address translator: chs to linear block, geometry and range check
// assumes geom_go is a one-cycle pulse from the command core
`include "dapm_cfg.svh"
module dapm_xlate #(
	parameter int unsigned TOTAL_SECTORS = `DAPM_TOTAL_SECTORS,
	parameter int unsigned DEF_SPT = `DAPM_DEF_SPT,
	parameter int unsigned DEF_HPC = `DAPM_DEF_HPC
) (
	input wire logic clk,
	input wire logic nrst,
	dapm_xlate_if.xlate xif
);
	localparam int unsigned DEF_CYLS_RAW = TOTAL_SECTORS / (DEF_SPT * DEF_HPC);
	localparam int unsigned DEF_CYLS = (DEF_CYLS_RAW > `DAPM_MAX_CYLS) ? `DAPM_MAX_CYLS : DEF_CYLS_RAW;

	function automatic logic [31:0] mac(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		mac = a * b + c;
	endfunction

	logic [7:0] spt_q;
	logic [4:0] hpc_q;
	logic [15:0] cyls_q;
	logic [31:0] rem_q;
	logic busy_q;
	wire [31:0] prod = {19'h0, 5'h0, spt_q} * {27'h0, hpc_q};
	wire [31:0] chs_lba = mac(mac({16'h0, xif.cyl}, {27'h0, hpc_q}, {28'h0, xif.head}), {24'h0, spt_q},
		{24'h0, xif.sect}) - 32'h1;
	wire chs_ok = (xif.sect != 8'h0) && (xif.sect <= spt_q) && ({1'b0, xif.head} < hpc_q) && (xif.cyl < cyls_q);
	wire [27:0] lba_flat = {xif.head, xif.cyl, xif.sect};

	// ----------------------------------------
	// translation
	// ----------------------------------------
	assign xif.lba = xif.lba_mode ? lba_flat : chs_lba[27:0];
	assign xif.in_range = xif.lba_mode ? ({4'h0, lba_flat} < TOTAL_SECTORS) : chs_ok;
	assign xif.geom_busy = busy_q;
	assign xif.cyls = cyls_q;

	// ----------------------------------------
	// geometry: cylinders by repeated subtraction, capped
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			spt_q <= 8'(DEF_SPT);
			hpc_q <= 5'(DEF_HPC);
			cyls_q <= 16'(DEF_CYLS);
			rem_q <= 32'h0;
			busy_q <= 1'b0;
		end else if (xif.geom_go) begin
			spt_q <= xif.new_spt;
			hpc_q <= xif.new_hpc;
			cyls_q <= 16'h0;
			rem_q <= TOTAL_SECTORS;
			busy_q <= (xif.new_spt != 8'h0);
		end else if (busy_q) begin
			if (rem_q >= prod && cyls_q != 16'(`DAPM_MAX_CYLS)) begin
				rem_q <= rem_q - prod;
				cyls_q <= cyls_q + 16'h1;
			end else begin
				busy_q <= 1'b0;
			end
		end
	end

	a_chs_origin: assert property (@(posedge clk) disable iff (!nrst)
		(!xif.lba_mode && xif.cyl == 16'h0 && xif.head == 4'h0 && xif.sect == 8'h1) |-> xif.lba == 28'h0)
		else $error("chs origin not block zero");
	a_sect_zero: assert property (@(posedge clk) disable iff (!nrst)
		(!xif.lba_mode && xif.sect == 8'h0) |-> !xif.in_range)
		else $error("sector zero accepted");
	a_lba_split: assert property (@(posedge clk) disable iff (!nrst)
		xif.lba_mode |-> (xif.lba[27:24] == xif.head && xif.lba[7:0] == xif.sect))
		else $error("linear address split wrong");
endmodule // dapm_xlate

// *** testbench/dapm_host_model.sv ***
// host-side model: drives taskfile strobes, reads back registers
// assumes one shared clock; device drops writes while busy
`include "dapm_cfg.svh"
module dapm_host_model (
	input wire logic clk,
	output logic tf_wr,
	output logic tf_rd,
	output logic [3:0] tf_sel,
	output logic [7:0] tf_wdata,
	input wire logic [7:0] tf_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		tf_wr = 1'b0;
		tf_rd = 1'b0;
		tf_sel = 4'h0;
		tf_wdata = 8'h00;
	end
	// -------------------------------
	// taskfile cycles
	// -------------------------------
	// released data shows the inverse, so stale bytes never look valid
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		tf_wr <= 1'b1;
		tf_sel <= s;
		tf_wdata <= d;
		@(posedge clk);
		tf_wr <= 1'b0;
		tf_wdata <= ~d;
	endtask
	task automatic rd(input logic [3:0] s, output logic [7:0] d);
		@(posedge clk);
		tf_rd <= 1'b1;
		tf_sel <= s;
		@(posedge clk);
		tf_rd <= 1'b0;
		@(posedge clk);
		#1 d = tf_rdata;
	endtask
	// select flag bit 6 set by caller for linear addressing
	task automatic load(input logic [7:0] dh, input logic [7:0] chi, input logic [7:0] clo, input logic [7:0] sn);
		wr(`DAPM_TF_DH, dh);
		wr(`DAPM_TF_CHI, chi);
		wr(`DAPM_TF_CLO, clo);
		wr(`DAPM_TF_SNUM, sn);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] cnt);
		wr(`DAPM_TF_SCNT, cnt);
		wr(`DAPM_TF_STAT, c);
	endtask
endmodule // dapm_host_model

// *** testbench/disk_addressing_power_modes_bench.sv ***
// bench for the addressing and power mode core
// assumes shortened spin-up, timer unit and capacity parameters
`include "dapm_cfg.svh"
module disk_addressing_power_modes_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TMR = 10;
	localparam int SPIN = 20;
	typedef struct packed {logic [7:0] dh, chi, clo, sn; logic err; logic [27:0] lba;} dapm_row_t;
	logic clk = 1'b0, nrst = 1'b0, soft_rst = 1'b0, cache_busy = 1'b0;
	logic tf_wr, tf_rd, iface_active, media_spin, media_req, seen_req, seen_act, seen_spin;
	logic [3:0] tf_sel;
	logic [7:0] tf_wdata, tf_rdata, status, rv;
	logic [4:0] power_mode;
	logic [27:0] media_lba;
	int err_count = 0, n_compared = 0, cyc = 0, n, fr;
	// too small a capacity to reach the top nibble without an error
	dapm_row_t rows[7] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 28'h0000000}, '{8'h02, 8'h00, 8'h01, 8'h03, 1'b0, 28'h0000470},
		'{8'h0f, 8'h00, 8'h00, 8'h3f, 1'b0, 28'h00003ef}, '{8'h40, 8'h00, 8'h12, 8'h34, 1'b0, 28'h0001234},
		'{8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 28'h0}, '{8'h00, 8'h00, 8'h00, 8'h40, 1'b1, 28'h0},
		'{8'h41, 8'h00, 8'h00, 8'h00, 1'b1, 28'h0}};
	always #20 clk = ~clk;
	dapm_host_model host_u (.clk(clk), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_sel(tf_sel), .tf_wdata(tf_wdata),
		.tf_rdata(tf_rdata));
	dapm_core #(.SPINUP_CYCLES(SPIN), .TMR_UNIT_CYCLES(TMR), .TOTAL_SECTORS(20000)) dut_u (.clk(clk), .nrst(nrst),
		.soft_rst(soft_rst), .cache_busy(cache_busy), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_sel(tf_sel),
		.tf_wdata(tf_wdata), .tf_rdata(tf_rdata), .status(status), .power_mode(power_mode),
		.iface_active(iface_active), .media_spin(media_spin), .media_req(media_req), .media_lba(media_lba));
	// -------------------------------
	// checking and closing
	// -------------------------------
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic note(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task automatic chk_b8(input logic [7:0] g, input logic [7:0] e, input string m); note(g === e, m); endtask
	task automatic chk_pm(input logic [4:0] e, input string m); note(power_mode === e, m); endtask
	task automatic chk_lba(input logic [27:0] e, input string m); note(media_lba === e, m); endtask
	task automatic chk_bit(input logic g, input logic e, input string m); note(g === e, m); endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	// waits out busy, noting media and mode activity on the way
	task automatic run();
		n = 0;
		fr = -1;
		{seen_req, seen_act, seen_spin} = 3'b000;
		@(posedge clk);
		#1;
		while (status[`DAPM_ST_BSY] !== 1'b0 && n < 200) begin
			seen_req |= media_req;
			seen_act |= power_mode === dapm_pkg::pm_active;
			seen_spin |= power_mode === dapm_pkg::pm_spinup;
			if (media_req === 1'b1 && fr < 0) fr = n;
			@(posedge clk);
			#1 n++;
		end
		note(n < 200, "busy never cleared");
	endtask
	task automatic go(input logic [7:0] c, input logic [7:0] cnt); host_u.cmd(c, cnt); run(); endtask
	// -------------------------------
	// main sequence
	// -------------------------------
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1 chk_b8(status, `DAPM_STAT_RST, "status after reset");
		host_u.rd(`DAPM_TF_SCNT, rv);
		chk_b8(rv, `DAPM_SCNT_RST, "sector count after reset");
		host_u.rd(`DAPM_TF_SNUM, rv);
		chk_b8(rv, `DAPM_SNUM_RST, "sector number after reset");
		foreach (rows[i]) begin
			host_u.load(rows[i].dh, rows[i].chi, rows[i].clo, rows[i].sn);
			host_u.wr(`DAPM_TF_STAT, `DAPM_CMD_READ);
			run();
			chk_bit(status[`DAPM_ST_ERR], rows[i].err, "address error flag");
			chk_bit(seen_req, !rows[i].err, "media access");
			if (!rows[i].err) chk_lba(rows[i].lba, "linear block");
			if (!rows[i].err) chk_bit(seen_act, 1'b1, "active while executing");
			if (!rows[i].err) note(fr == 0, "idle access delayed");
		end
		// new geometry: 100 sectors, 10 heads, so 20 cylinders in the short capacity
		host_u.load(8'h09, 8'h00, 8'h00, 8'h01);
		go(`DAPM_CMD_INITP, 8'h64);
		host_u.load(8'h02, 8'h00, 8'h01, 8'h05);
		host_u.wr(`DAPM_TF_STAT, `DAPM_CMD_WRITE);
		run();
		chk_lba(28'h00004b4, "block under new geometry");
		host_u.load(8'h09, 8'h00, 8'h13, 8'h64);
		host_u.wr(`DAPM_TF_STAT, `DAPM_CMD_READ);
		run();
		chk_lba(28'h0004e1f, "last block under new geometry");
		host_u.load(8'h40, 8'h00, 8'h12, 8'h34);
		host_u.wr(`DAPM_TF_STAT, `DAPM_CMD_READ);
		run();
		chk_lba(28'h0001234, "linear block ignores geometry");
		host_u.load(8'h00, 8'h00, 8'h14, 8'h01);
		host_u.wr(`DAPM_TF_STAT, `DAPM_CMD_READ);
		run();
		chk_bit(status[`DAPM_ST_ERR], 1'b1, "cylinder past new count");
		go(`DAPM_CMD_CHKPWR, 8'h00);
		host_u.rd(`DAPM_TF_SCNT, rv);
		chk_b8(rv, `DAPM_PWR_SPUN, "power query spun");
		go(`DAPM_CMD_STBY_IMM, 8'h00);
		chk_pm(dapm_pkg::pm_standby, "standby now");
		chk_b8(status, `DAPM_STAT_RST, "standby status");
		chk_bit(media_spin, 1'b0, "spindle stopped");
		go(`DAPM_CMD_CHKPWR, 8'h00);
		host_u.rd(`DAPM_TF_SCNT, rv);
		chk_b8(rv, `DAPM_PWR_STANDBY, "power query standby");
		host_u.load(8'h00, 8'h00, 8'h00, 8'h01);
		host_u.wr(`DAPM_TF_STAT, `DAPM_CMD_READ);
		run();
		chk_bit(seen_spin, 1'b1, "spin-up seen");
		note(fr == SPIN - 1, "media before spin-up");
		go(`DAPM_CMD_STBY, 8'h00);
		chk_pm(dapm_pkg::pm_standby, "timed standby");
		go(`DAPM_CMD_IDLE_IMM, 8'h00);
		chk_pm(dapm_pkg::pm_idle, "idle from standby");
		chk_bit(media_spin, 1'b1, "spindle on in idle");
		cache_busy <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk_pm(dapm_pkg::pm_active, "caching is active");
		cache_busy <= 1'b0;
		go(`DAPM_CMD_IDLE, 8'h00);
		repeat (60) @(posedge clk);
		#1 chk_pm(dapm_pkg::pm_idle, "timer off stays idle");
		go(`DAPM_CMD_IDLE, 8'h02);
		repeat (2 * TMR - 5) @(posedge clk);
		#1 chk_pm(dapm_pkg::pm_idle, "idle before expiry");
		repeat (10) @(posedge clk);
		#1 chk_pm(dapm_pkg::pm_standby, "standby on expiry");
		go(`DAPM_CMD_SLEEP, 8'h00);
		chk_pm(dapm_pkg::pm_sleep, "sleep entered");
		chk_bit(iface_active, 1'b0, "interface dead");
		host_u.wr(`DAPM_TF_STAT, `DAPM_CMD_IDLE_IMM);
		repeat (3) @(posedge clk);
		#1 chk_pm(dapm_pkg::pm_sleep, "command cannot wake");
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		@(posedge clk);
		#1 chk_pm(dapm_pkg::pm_standby, "reset wakes to standby");
		chk_b8(status, `DAPM_STAT_RST, "status after soft reset");
		host_u.rd(`DAPM_TF_SCNT, rv);
		chk_b8(rv, `DAPM_SCNT_RST, "count after soft reset");
		report_and_stop();
	end
endmodule // disk_addressing_power_modes_bench
